/* rtl/srh_receiver.sv */
// Notes on behaviour
// - Modes 4 to 7 are receive only; nothing is ever transmitted.
// - Fast modes drive three active-high outputs with 20 ms hang-time.
// - Mode 7 filters by learned sender; mode 6 accepts every packet.
// - Networked mode: learn pulse starts learning; pin then shows status.
// - Outputs follow the three received switch bits; all 8 patterns.
// - A high output holds for the hang-time, then drops without packets.
// - A packet inside the hang-time restarts it for held outputs.
// - Output stays high while packets keep reporting its input high.
// - With 20 ms hang-time, all-off costs only about 5 ms extra.
// - Long hang-time holds the last output 500 ms after input drops.
// - Output rises about 5 ms, at most 12 ms, after input rises.
// - Switch states come from bits 6 down to 4 of byte one.
// - A single all-zero state byte turns every output off at once.
// - Networked modes accept only packets from learned senders.
// - Mode straps are sampled once leaving reset, low strap is bit 0.
`timescale 1ns/100ps
module srh_receiver #(
   parameter int HANG_FAST = srh_pkg::HANG_FAST_CYC,
   parameter int HANG_SLOW = srh_pkg::HANG_SLOW_CYC,
   parameter int LEARN_CYC = srh_pkg::LEARN_CYC,
   parameter int DEPTH = srh_pkg::TABLE_DEPTH
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire srh_pkg::srh_strap_type straps,
   input wire logic packet_valid,
   input wire srh_pkg::srh_packet_type packet,
   input wire logic learn_status_in,
   output logic learn_status_out,
   output logic learn_status_oe_n,
   output logic switch_output_first,
   output logic switch_output_second,
   output logic switch_output_third,
   output logic receiver_ready,
   output logic transmit_enable
);
   typedef enum logic [1:0] {
      SRH_STRAP,
      SRH_RUN,
      SRH_LEARN
   } srh_state_type;

   srh_state_type state;
   srh_state_type next_state;
   logic [2:0] mode;
   logic [2:0] next_mode;
   logic [srh_pkg::LEARN_W-1:0] learn_cnt;
   logic [srh_pkg::LEARN_W-1:0] next_learn_cnt;
   logic learn_prev;
   logic next_learn_prev;
   logic pkt_q;
   logic [2:0] bits_q;
   logic zero_q;
   logic [2:0] next_bits_q;
   logic next_zero_q;
   logic next_pkt_q;
   logic [srh_pkg::SERIAL_W-1:0] serial_q;
   logic [srh_pkg::SERIAL_W-1:0] next_serial_q;
   logic table_hit;
   logic table_wr;
   logic networked;
   logic accept;
   logic kill;
   logic [srh_pkg::CNT_W-1:0] hang_cyc;
   logic [2:0] active;

   // Learn pin decode and output stage next values
   logic learn_rise;
   logic learn_timeout;
   logic learning;
   logic next_switch_first;
   logic next_switch_second;
   logic next_switch_third;
   logic next_learn_status_out;
   logic next_learn_status_oe_n;
   logic next_receiver_ready;
   logic next_transmit_enable;

   function automatic logic is_networked(input logic [2:0] m);
      return m == srh_pkg::MODE_SLOW_NET || m == srh_pkg::MODE_FAST_NET;
   endfunction

   // Modes 0 to 3 fall back to the long hang-time
   function automatic logic is_fast(input logic [2:0] m);
      return m == srh_pkg::MODE_FAST_PLAIN || m == srh_pkg::MODE_FAST_NET;
   endfunction

   function automatic logic [2:0] switch_bits(input logic [7:0] b);
      return b[srh_pkg::STATE_MSB:srh_pkg::STATE_LSB];
   endfunction

   // Only a one-byte packet counts; a zero byte with a header is a state
   function automatic logic is_zero_kill(input srh_pkg::srh_packet_type p);
      return p.single_byte && p.state_byte == 8'h00;
   endfunction

   assign networked = is_networked(mode);
   assign learning = state == SRH_LEARN;
   // Pin idles low through its pull-down, so prev starts low
   assign learn_rise = learn_status_in && !learn_prev;
   assign learn_timeout = learn_cnt <= srh_pkg::LEARN_W'(1);

   // Hang-time by mode
   always_comb
   begin
      if (is_fast(mode))
      begin
         hang_cyc = srh_pkg::CNT_W'(HANG_FAST);
      end
      else
      begin
         hang_cyc = srh_pkg::CNT_W'(HANG_SLOW);
      end
   end

   // Mode and learn sequencing
   always_comb
   begin
      next_state = state;
      next_mode = mode;
      next_learn_cnt = learn_cnt;
      next_learn_prev = learn_status_in;
      table_wr = 1'b0;
      case (state)
         SRH_STRAP:
         begin
            // Straps settle during reset; read them once here
            // sample straps
            next_mode = {straps.mode_strap_high, straps.mode_strap_mid,
                         straps.mode_strap_low};
            next_state = SRH_RUN;
         end
         SRH_RUN:
         begin
            if (networked && learn_rise)
            begin
               next_state = SRH_LEARN;
               next_learn_cnt = srh_pkg::LEARN_W'(LEARN_CYC);
            end
         end
         SRH_LEARN:
         begin
            // Learning ends on the first packet of either kind, storing its serial, or on window timeout
            if (pkt_q)
            begin
               table_wr = 1'b1;
               next_state = SRH_RUN;
            end
            else if (learn_timeout)
            begin
               // A missed window leaves the table unchanged
               next_state = SRH_RUN;
            end
            else
            begin
               next_learn_cnt = learn_cnt - 1'b1;
            end
         end
         default:
         begin
            next_state = SRH_STRAP;
         end
      endcase
   end

   // Packet capture stage
   // one-cycle latency
   always_comb
   begin
      next_pkt_q = packet_valid && state != SRH_STRAP;
      next_bits_q = bits_q;
      next_zero_q = zero_q;
      next_serial_q = serial_q;
      if (packet_valid)
      begin
         next_bits_q = switch_bits(packet.state_byte);
         next_zero_q = is_zero_kill(packet);
         // Serial is held for the table write after a learn packet
         next_serial_q = packet.sender_serial_number;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         state <= SRH_STRAP;
         mode <= 3'h0;
         learn_cnt <= '0;
         learn_prev <= 1'b0;
         pkt_q <= 1'b0;
         bits_q <= 3'h0;
         zero_q <= 1'b0;
         serial_q <= '0;
      end
      else
      begin
         state <= next_state;
         mode <= next_mode;
         learn_cnt <= next_learn_cnt;
         learn_prev <= next_learn_prev;
         pkt_q <= next_pkt_q;
         bits_q <= next_bits_q;
         zero_q <= next_zero_q;
         serial_q <= next_serial_q;
      end
   end

   // Lookup uses the live bus so the hit lines up with pkt_q
   srh_serial_table #(
      .DEPTH(DEPTH),
      .AW(srh_pkg::TABLE_AW)
   ) u_table (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .wr_en(table_wr),
      .wr_serial(serial_q),
      .lookup_serial(packet.sender_serial_number),
      .hit(table_hit)
   );

   // Packets seen while learning are stored, never applied
   always_comb
   begin
      accept = 1'b0;
      if (pkt_q && state == SRH_RUN)
      begin
         accept = !networked || table_hit;
      end
      kill = accept && zero_q;
   end

   // Timers read hang_cyc live; new straps need a reset anyway
   // Kill beats load so a zero byte never re-arms a timer
   // per-output counters
   for (genvar g = 0; g < 3; g++)
   begin : g_hang
      srh_hang_timer #(
         .CNT_W(srh_pkg::CNT_W)
      ) u_hang (
         .clk_sys(clk_sys),
         .rst_n(rst_n),
         .load(accept),
         .value(bits_q[g]),
         .kill(kill),
         .hang_cyc(hang_cyc),
         .active(active[g])
      );
   end

   // Output stage
   always_comb
   begin
      next_switch_first = active[0];
      next_switch_second = active[1];
      next_switch_third = active[2];
      next_learn_status_out = learning;
      // Release pin while idle so the learn pulse can be sensed
      next_learn_status_oe_n = !learning;
      // Ready only once the mode is known
      next_receiver_ready = state != SRH_STRAP;
      next_transmit_enable = 1'b0;
   end

   // Registered pins keep decode glitches off the board
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         switch_output_first <= 1'b0;
         switch_output_second <= 1'b0;
         switch_output_third <= 1'b0;
         learn_status_out <= 1'b0;
         learn_status_oe_n <= 1'b1;
         receiver_ready <= 1'b0;
         transmit_enable <= 1'b0;
      end
      else
      begin
         switch_output_first <= next_switch_first;
         switch_output_second <= next_switch_second;
         switch_output_third <= next_switch_third;
         learn_status_out <= next_learn_status_out;
         learn_status_oe_n <= next_learn_status_oe_n;
         receiver_ready <= next_receiver_ready;
         transmit_enable <= next_transmit_enable;
      end
   end
endmodule

/* rtl/srh_pkg.sv */
package srh_pkg;
   localparam int CLK_HZ = 10000000;
   localparam int HANG_FAST_MS = 20;
   localparam int HANG_SLOW_MS = 500;
   localparam int LEARN_WINDOW_MS = 10000;
   localparam int HANG_FAST_CYC = HANG_FAST_MS * (CLK_HZ / 1000);
   localparam int HANG_SLOW_CYC = HANG_SLOW_MS * (CLK_HZ / 1000);
   localparam int LEARN_CYC = LEARN_WINDOW_MS * (CLK_HZ / 1000);
   localparam int CNT_W = 24;
   localparam int LEARN_W = 27;
   localparam int SERIAL_W = 32;
   localparam int TABLE_DEPTH = 8;
   localparam int TABLE_AW = 3;
   localparam int STATE_LSB = 4;
   localparam int STATE_MSB = 6;
   localparam logic [2:0] MODE_SLOW_PLAIN = 3'h4;
   localparam logic [2:0] MODE_SLOW_NET = 3'h5;
   localparam logic [2:0] MODE_FAST_PLAIN = 3'h6;
   localparam logic [2:0] MODE_FAST_NET = 3'h7;

   typedef struct packed {
      logic [7:0] state_byte;
      logic [SERIAL_W-1:0] sender_serial_number;
      logic single_byte;
   } srh_packet_type;

   typedef struct packed {
      logic mode_strap_high;
      logic mode_strap_mid;
      logic mode_strap_low;
   } srh_strap_type;
endpackage

/* rtl/srh_serial_table.sv */
`timescale 1ns/100ps
module srh_serial_table #(
   parameter int DEPTH = srh_pkg::TABLE_DEPTH,
   parameter int AW = srh_pkg::TABLE_AW
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [srh_pkg::SERIAL_W-1:0] wr_serial,
   input wire logic [srh_pkg::SERIAL_W-1:0] lookup_serial,
   output logic hit
);
   logic [srh_pkg::SERIAL_W-1:0] mem [DEPTH];
   logic [DEPTH-1:0] used;
   logic [AW-1:0] wr_ptr;
   logic [DEPTH-1:0] next_used;
   logic [AW-1:0] next_wr_ptr;
   logic next_hit;

   always_comb
   begin
      next_used = used;
      next_wr_ptr = wr_ptr;
      next_hit = 1'b0;
      for (int i = 0; i < DEPTH; i++)
      begin
         if (used[i] && mem[i] == lookup_serial)
         begin
            next_hit = 1'b1;
         end
      end
      if (wr_en)
      begin
         next_used[wr_ptr] = 1'b1;
         next_wr_ptr = AW'(wr_ptr + 1'b1);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         used <= '0;
         wr_ptr <= '0;
         hit <= 1'b0;
      end
      else
      begin
         used <= next_used;
         wr_ptr <= next_wr_ptr;
         hit <= next_hit;
      end
   end

   // Storage itself needs no reset; validity lives in used
   always_ff @(posedge clk_sys)
   begin
      if (wr_en)
      begin
         mem[wr_ptr] <= wr_serial;
      end
   end
endmodule

/* rtl/srh_hang_timer.sv */
`timescale 1ns/100ps
module srh_hang_timer #(
   parameter int CNT_W = srh_pkg::CNT_W
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic load,
   input wire logic value,
   input wire logic kill,
   input wire logic [CNT_W-1:0] hang_cyc,
   output logic active
);
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   logic next_active;

   always_comb
   begin
      next_count = count;
      next_active = active;
      if (kill)
      begin
         next_count = '0;
         next_active = 1'b0;
      end
      else if (load)
      begin
         next_active = value;
         next_count = value ? hang_cyc : '0;
      end
      else if (active)
      begin
         if (count <= CNT_W'(1))
         begin
            next_active = 1'b0;
            next_count = '0;
         end
         else
         begin
            next_count = count - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         count <= '0;
         active <= 1'b0;
      end
      else
      begin
         count <= next_count;
         active <= next_active;
      end
   end
endmodule

/* tb/srh_chk.sv */
`timescale 1ns/100ps
module srh_chk #(parameter int HANG_FAST = 20) (
   input logic clk_sys,
   input logic rst_n,
   input srh_pkg::srh_strap_type straps,
   input logic packet_valid,
   input srh_pkg::srh_packet_type packet,
   input logic learn_status_out,
   input logic learn_status_oe_n,
   input logic switch_output_first,
   input logic switch_output_second,
   input logic switch_output_third,
   input logic receiver_ready,
   input logic transmit_enable
);
   logic [2:0] outs;
   logic [23:0] idle;
   logic [23:0] next_idle;
   assign outs = {switch_output_third, switch_output_second,
      switch_output_first};
   // Saturates so a long gap never wraps to a small count
   always_comb next_idle = packet_valid ? 24'h000000 :
      idle + {23'h000000, idle != 24'hffffff};
   always_ff @(posedge clk_sys) idle <= rst_n ? next_idle : 24'hffffff;
   default clocking @(posedge clk_sys); endclocking
   sequence s_plain_pkt;
      packet_valid && receiver_ready && !straps.mode_strap_low;
   endsequence
   sequence s_outs_off;
      ##3 outs == 3'h0;
   endsequence
   property p_follow;
      logic [2:0] b;
      disable iff (!rst_n)
      (s_plain_pkt, b = packet.state_byte[6:4]) |-> ##3 outs == b;
   endproperty
   a_no_transmit:
      assert property (disable iff (!rst_n) !transmit_enable)
      else $error("transmit enable raised");
   a_outs_follow:
      assert property (p_follow) else $error("outputs differ from bits");
   a_zero_kill:
      assert property (disable iff (!rst_n) s_plain_pkt ##0
         (packet.single_byte && packet.state_byte == 8'h00) |-> s_outs_off)
      else $error("zero byte left an output on");
   a_hang_bound:
      assert property (disable iff (!rst_n) straps.mode_strap_high &&
         straps.mode_strap_mid && outs != 3'h0 |-> idle <= HANG_FAST + 3)
      else $error("output held past hang time");
   a_reset_clear:
      assert property (!rst_n |=> outs == 3'h0 && learn_status_oe_n &&
         !receiver_ready) else $error("reset left state");
   a_ready_rise:
      assert property (disable iff (!rst_n) $rose(rst_n) |->
         ##[1:2] receiver_ready) else $error("ready late");
   a_status_drive:
      assert property (disable iff (!rst_n)
         learn_status_oe_n == !learn_status_out)
      else $error("status pin drive mismatch");
   a_plain_quiet:
      assert property (disable iff (!rst_n)
         !straps.mode_strap_low |-> learn_status_oe_n)
      else $error("plain mode drove status pin");
   a_rise_latency:
      assert property (disable iff (!rst_n) s_plain_pkt ##0
         packet.state_byte[4] |-> ##3 switch_output_first)
      else $error("output rose late");
endmodule
bind srh_receiver srh_chk #(.HANG_FAST(HANG_FAST)) u_chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .straps(straps),
   .packet_valid(packet_valid), .packet(packet),
   .learn_status_out(learn_status_out),
   .learn_status_oe_n(learn_status_oe_n),
   .switch_output_first(switch_output_first),
   .switch_output_second(switch_output_second),
   .switch_output_third(switch_output_third),
   .receiver_ready(receiver_ready), .transmit_enable(transmit_enable));

/* tb/srh_tx_model.sv */
`timescale 1ns/100ps
module srh_tx_model #(parameter int PERIOD = 15) (
   input logic clk_sys,
   input logic go,
   input logic auto_on,
   input logic [7:0] tx_byte,
   input logic single,
   input logic [31:0] serial,
   output logic packet_valid,
   output srh_pkg::srh_packet_type packet
);
   logic [7:0] cnt;
   srh_pkg::srh_packet_type last;
   assign packet_valid = go || (auto_on && cnt == 8'h00);
   always_ff @(posedge clk_sys)
   begin
      cnt <= (cnt == 8'h00 || !auto_on) ? 8'(PERIOD - 1) : cnt - 8'h01;
      last <= packet_valid ? packet : last;
   end
   // Idle bus shows inverted data so stale values are never trusted
   assign packet = packet_valid ? {tx_byte, serial, single} : ~last;
endmodule

/* tb/srh_receiver_tb.sv */
`timescale 1ns/100ps
module srh_receiver_tb;
   localparam int HF = 20;
   logic clk_sys = 1'b0;
   logic rst_n, go, auto_on, single, learn_drive, pv, lpin;
   logic ls_out, ls_oe_n, o1, o2, o3, rdy, tx_en;
   logic [7:0] tx_byte;
   logic [31:0] serial;
   srh_pkg::srh_strap_type straps;
   srh_pkg::srh_packet_type pkt;
   int fail_count = 0;
   int num_checks = 0;
   logic [7:0] row_in [8] = '{8'h10, 8'h21, 8'h3f, 8'hc0, 8'h58, 8'h6e,
      8'hff, 8'h8f};
   logic [2:0] row_exp [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7,
      3'h0};
   // Pull-down on the shared pin when nobody drives it
   assign lpin = ls_oe_n ? learn_drive : ls_out;
   always #50 clk_sys = ~clk_sys;
   srh_tx_model u_tx (.clk_sys(clk_sys), .go(go), .auto_on(auto_on),
      .tx_byte(tx_byte), .single(single), .serial(serial),
      .packet_valid(pv), .packet(pkt));
   srh_receiver #(.HANG_FAST(HF), .HANG_SLOW(50), .LEARN_CYC(100)) dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .straps(straps),
      .packet_valid(pv), .packet(pkt), .learn_status_in(lpin),
      .learn_status_out(ls_out), .learn_status_oe_n(ls_oe_n),
      .switch_output_first(o1), .switch_output_second(o2),
      .switch_output_third(o3), .receiver_ready(rdy),
      .transmit_enable(tx_en));
   task automatic chk(input logic [2:0] g, input logic [2:0] e);
      num_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("Error t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic send(input logic [7:0] b, input logic s,
      input logic [31:0] sn);
      @(negedge clk_sys);
      tx_byte = b;
      single = s;
      serial = sn;
      go = 1'b1;
      @(negedge clk_sys);
      go = 1'b0;
      repeat (3) @(negedge clk_sys);
   endtask
   task automatic wait_chk(input int n, input logic [2:0] e);
      repeat (n) @(negedge clk_sys);
      chk({o3, o2, o1}, e);
   endtask
   task automatic restart(input logic [2:0] m);
      rst_n = 1'b0;
      straps = m;
      repeat (3) @(negedge clk_sys);
      chk({o3, o2, o1}, 3'h0);
      rst_n = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk({2'b00, rdy}, 3'h1);
   endtask
   task give_verdict;
      if (fail_count == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (3000) @(posedge clk_sys);
      fail_count++;
      give_verdict();
   end
   initial
   begin
      {rst_n, go, auto_on, single, learn_drive, tx_byte, serial} = '0;
      straps = srh_pkg::MODE_FAST_PLAIN;
      repeat (12) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (3) @(negedge clk_sys);
      for (int i = 0; i < 8; i++)
      begin
         send(row_in[i], 1'b0, 32'h0);
         chk({o3, o2, o1}, row_exp[i]);
      end
      send(8'h70, 1'b0, 32'h0);
      auto_on = 1'b1;
      for (int i = 0; i < 90; i++)
         wait_chk(1, 3'h7);
      auto_on = 1'b0;
      send(8'h70, 1'b0, 32'h0);
      wait_chk(HF - 2, 3'h7);
      wait_chk(1, 3'h0);
      wait_chk(4, 3'h0);
      send(8'h70, 1'b0, 32'h0);
      send(8'h10, 1'b0, 32'h0);
      chk({o3, o2, o1}, 3'h1);
      send(8'h00, 1'b1, 32'h0);
      chk({o3, o2, o1}, 3'h0);
      straps = srh_pkg::MODE_FAST_NET;
      send(8'h30, 1'b0, 32'h0000_00aa);
      chk({o3, o2, o1}, 3'h3);
      restart(srh_pkg::MODE_FAST_NET);
      send(8'h70, 1'b0, 32'h1234_5678);
      chk({o3, o2, o1}, 3'h0);
      @(negedge clk_sys);
      learn_drive = 1'b1;
      @(negedge clk_sys);
      learn_drive = 1'b0;
      repeat (4) @(negedge clk_sys);
      chk({1'b0, ls_out, ls_oe_n}, 3'h2);
      send(8'h70, 1'b0, 32'h1234_5678);
      chk({ls_out, o2, o1}, 3'h0);
      send(8'h50, 1'b0, 32'h1234_5678);
      chk({o3, o2, o1}, 3'h5);
      send(8'h70, 1'b0, 32'h8765_4321);
      chk({o3, o2, o1}, 3'h5);
      restart(srh_pkg::MODE_SLOW_PLAIN);
      send(8'h10, 1'b0, 32'h0);
      wait_chk(35, 3'h1);
      wait_chk(20, 3'h0);
      chk({2'b00, tx_en}, 3'h0);
      give_verdict();
   end
endmodule
